// ==== core/board_power_pkg.sv ====
// constants, status layout and states for the board power and status logic
package board_power_pkg;

  // ==========================================================
  // clocks and timers
  localparam int unsigned REF_CLK_HZ = 20_000_000;
  localparam int unsigned SUSP_CLK_HZ = 32_000;
  localparam int unsigned TICK_HZ = 500;
  localparam int unsigned SUSP_DIV = SUSP_CLK_HZ / TICK_HZ;
  localparam int unsigned PG_DELAY_MS = 100;
  localparam int unsigned PG_DELAY_TICKS = PG_DELAY_MS * TICK_HZ / 1000;
  localparam int unsigned DEB_TICKS = 4;
  localparam logic [5:0] SUSP_DIV_LAST = 6'(SUSP_DIV - 1);
  localparam logic [5:0] PG_DELAY_LAST = 6'(PG_DELAY_TICKS);
  localparam logic [2:0] DEB_LAST = 3'(DEB_TICKS);

  // ==========================================================
  // utilisation thresholds in percent
  localparam logic [6:0] UTIL_DUAL_LOW = 7'h25;
  localparam logic [6:0] UTIL_DUAL_HIGH = 7'h2D;
  localparam logic [6:0] UTIL_ONE_LOW = 7'h4A;
  localparam logic [6:0] UTIL_ONE_HIGH = 7'h5A;

  // ==========================================================
  // status vector layout, bit 0 leaves first
  localparam int unsigned STAT_W = 27;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam logic [4:0] STAT_LAST = 5'h1A;
  localparam int unsigned ST_CPU_FAIL = 0;
  localparam int unsigned ST_FRU_FAIL = 4;
  localparam int unsigned ST_NONRED = 12;
  localparam int unsigned ST_DIRTY = 13;
  localparam int unsigned ST_PRESENT = 14;
  localparam int unsigned ST_SUP_OK = 16;
  localparam int unsigned ST_SYS_GOOD = 18;
  localparam int unsigned ST_SLOT_GOOD = 19;
  localparam int unsigned ST_THROTTLE = 23;
  localparam int unsigned ST_BREAKER = 24;
  localparam int unsigned ST_LINE = 25;
  localparam int unsigned ST_SUPPLY_OK = 26;
  localparam logic [26:0] STAT_RESET = 27'h0000000;

  // ==========================================================
  // shift engine states, gray along idle, run, done
  typedef enum logic [1:0] {
    SH_IDLE = 2'h0,
    SH_RUN = 2'h1,
    SH_DONE = 2'h3
  } shift_state_e;

endpackage

// ==== core/status_fifo.sv ====
// flip-flop fifo that holds pending status snapshots
`timescale 1ns/100ps
module status_fifo #(
  parameter int unsigned WIDTH = 27,
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wr_ptr_r;
  logic [AW:0] rd_ptr_r;
  logic push;
  logic pop;

  // ==========================================================
  // flags; extra pointer bit tells full from empty
  assign out_valid_o = (wr_ptr_r != rd_ptr_r);
  assign in_ready_o = (wr_ptr_r[AW-1:0] != rd_ptr_r[AW-1:0]) || (wr_ptr_r[AW] == rd_ptr_r[AW]);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem_r[rd_ptr_r[AW-1:0]];

  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem_r[wr_ptr_r[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end

endmodule // status_fifo

// ==== core/board_power_status_logic.sv ====
// power sequencing, failure capture, serial status link and slot delays
`timescale 1ns/100ps
module board_power_status_logic (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic suspend_clock_i,
  // supplies and rails
  input wire logic [1:0] supply_present_in_i,
  input wire logic [1:0] supply_ok_in_i,
  input wire logic power_request_i,
  input wire logic rail_1v5_good_i,
  input wire logic term_reg_good_i,
  input wire logic [3:0] socket_occupied_n_i,
  input wire logic [3:0] cpu_reg_good_i,
  input wire logic [7:0] fru_good_i,
  input wire logic [3:0] riser_present_i,
  // slots
  input wire logic [3:0] slot_3v3_good_i,
  input wire logic [3:0] slot_stby_good_i,
  // power budget
  input wire logic breaker_setting_i,
  input wire logic [6:0] utilization_i,
  input wire logic line_range_sense_i,
  input wire logic s5_state_i,
  // status link from the management controller
  input wire logic latch_strobe_i,
  input wire logic shift_clk_i,
  // sequencing outputs
  output logic supply_ok_out_o,
  output logic supply_on_n_o,
  output logic term_reg_enable_o,
  output logic [3:0] cpu_reg_enable_o,
  output logic global_reg_enable_o,
  output logic io_riser_enable_o,
  output logic clock_enable_n_o,
  output logic system_good_out_o,
  // slot outputs
  output logic [3:0] slot_good_o,
  output logic [3:0] slot_iso_enable_o,
  // status outputs
  output logic nonredundant_o,
  output logic cpu_throttle_n_o,
  output logic shift_data_o
);

  // ==========================================================
  // input synchronisers, every pin passes two flops
  localparam int unsigned NSYNC = 48;

  logic [NSYNC-1:0] pins;
  logic [NSYNC-1:0] sync1_r;
  logic [NSYNC-1:0] sync2_r;

  assign pins = {suspend_clock_i, shift_clk_i, latch_strobe_i, s5_state_i,
                 line_range_sense_i, utilization_i, breaker_setting_i,
                 slot_stby_good_i, slot_3v3_good_i, socket_occupied_n_i,
                 riser_present_i, fru_good_i, cpu_reg_good_i, term_reg_good_i,
                 rail_1v5_good_i, power_request_i, supply_ok_in_i,
                 supply_present_in_i};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
        end else begin
          sync1_r[gi] <= pins[gi];
          sync2_r[gi] <= sync1_r[gi];
        end
      end
    end
  endgenerate

  logic [3:0] sup_raw;
  logic power_req;
  logic rail_1v5;
  logic term_good;
  logic [3:0] cpu_good;
  logic [7:0] fru_good;
  logic [3:0] riser;
  logic [3:0] occ_n;
  logic [3:0] slot_3v3;
  logic [3:0] slot_stby;
  logic breaker_low;
  logic [6:0] util;
  logic line_high;
  logic in_s5;
  logic latch_s;
  logic sclk_s;
  logic susp_s;

  // multi-bit utilisation may tear for one cycle; the threshold only rounds
  assign sup_raw = sync2_r[3:0];
  assign power_req = sync2_r[4];
  assign rail_1v5 = sync2_r[5];
  assign term_good = sync2_r[6];
  assign cpu_good = sync2_r[10:7];
  assign fru_good = sync2_r[18:11];
  assign riser = sync2_r[22:19];
  assign occ_n = sync2_r[26:23];
  assign slot_3v3 = sync2_r[30:27];
  assign slot_stby = sync2_r[34:31];
  assign breaker_low = sync2_r[35];
  assign util = sync2_r[42:36];
  assign line_high = sync2_r[43];
  assign in_s5 = sync2_r[44];
  assign latch_s = sync2_r[45];
  assign sclk_s = sync2_r[46];
  assign susp_s = sync2_r[47];

  // ==========================================================
  // 500 Hz tick from the suspend clock
  logic susp_d_r;
  logic [5:0] div_r;
  logic tick;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      susp_d_r <= 1'b0;
      div_r <= '0;
    end else begin
      susp_d_r <= susp_s;
      if (susp_s && !susp_d_r) begin
        div_r <= (div_r == board_power_pkg::SUSP_DIV_LAST) ? 6'h00 : div_r + 6'h01;
      end
    end
  end

  assign tick = susp_s && !susp_d_r && (div_r == board_power_pkg::SUSP_DIV_LAST);

  // ==========================================================
  // supply debounce: present a/b, ok a/b
  logic [3:0] sup_db_r;
  logic [3:0] sup_cand_r;
  logic [2:0] deb_cnt_r [4];

  generate
    for (gi = 0; gi < 4; gi++) begin : g_deb
      always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          sup_db_r[gi] <= 1'b0;
          sup_cand_r[gi] <= 1'b0;
          deb_cnt_r[gi] <= '0;
        end else if (sup_raw[gi] != sup_cand_r[gi]) begin
          sup_cand_r[gi] <= sup_raw[gi];
          deb_cnt_r[gi] <= '0;
        end else if (tick) begin
          if (deb_cnt_r[gi] == board_power_pkg::DEB_LAST) begin
            sup_db_r[gi] <= sup_cand_r[gi];
          end else begin
            deb_cnt_r[gi] <= deb_cnt_r[gi] + 3'h1;
          end
        end
      end
    end
  endgenerate

  logic [1:0] present;
  logic [1:0] sup_ok;
  logic cpu_present;

  assign present = sup_db_r[1:0];
  assign sup_ok = sup_db_r[3:2];
  assign cpu_present = ~&occ_n;

  // ==========================================================
  // regulator chain
  logic sys_good_int;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      supply_on_n_o <= 1'b1;
      supply_ok_out_o <= 1'b0;
      term_reg_enable_o <= 1'b0;
      cpu_reg_enable_o <= '0;
      global_reg_enable_o <= 1'b0;
      io_riser_enable_o <= 1'b0;
      sys_good_int <= 1'b0;
      clock_enable_n_o <= 1'b1;
    end else begin
      supply_on_n_o <= !(power_req && cpu_present);
      supply_ok_out_o <= &present && &sup_ok;
      term_reg_enable_o <= supply_ok_out_o && rail_1v5;
      cpu_reg_enable_o <= (term_reg_enable_o && term_good) ? ~occ_n : 4'h0;
      global_reg_enable_o <= |cpu_reg_enable_o && term_reg_enable_o && |riser;
      io_riser_enable_o <= |cpu_reg_enable_o && term_reg_enable_o && |riser;
      sys_good_int <= &fru_good;
      clock_enable_n_o <= !(&fru_good);
    end
  end

  // ==========================================================
  // delayed system good
  logic [5:0] sys_cnt_r;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sys_cnt_r <= '0;
      system_good_out_o <= 1'b0;
    end else if (!sys_good_int) begin
      sys_cnt_r <= '0;
      system_good_out_o <= 1'b0;
    end else if (tick && sys_cnt_r != board_power_pkg::PG_DELAY_LAST) begin
      sys_cnt_r <= sys_cnt_r + 6'h01;
    end else if (sys_cnt_r == board_power_pkg::PG_DELAY_LAST) begin
      system_good_out_o <= 1'b1;
    end
  end

  // ==========================================================
  // hot-plug slot delays, one timer pair per slot
  logic [5:0] slot_cnt_r [4];
  logic [5:0] iso_cnt_r [4];

  generate
    for (gi = 0; gi < 4; gi++) begin : g_slot
      always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          slot_cnt_r[gi] <= '0;
          slot_good_o[gi] <= 1'b0;
        end else if (!slot_3v3[gi]) begin
          slot_cnt_r[gi] <= '0;
          slot_good_o[gi] <= 1'b0;
        end else if (slot_cnt_r[gi] == board_power_pkg::PG_DELAY_LAST) begin
          slot_good_o[gi] <= 1'b1;
        end else if (tick) begin
          slot_cnt_r[gi] <= slot_cnt_r[gi] + 6'h01;
        end
      end

      always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          iso_cnt_r[gi] <= '0;
          slot_iso_enable_o[gi] <= 1'b0;
        end else if (!slot_stby[gi]) begin
          iso_cnt_r[gi] <= '0;
          slot_iso_enable_o[gi] <= 1'b0;
        end else if (iso_cnt_r[gi] == board_power_pkg::PG_DELAY_LAST) begin
          slot_iso_enable_o[gi] <= 1'b1;
        end else if (tick) begin
          iso_cnt_r[gi] <= iso_cnt_r[gi] + 6'h01;
        end
      end
    end
  endgenerate

  // ==========================================================
  // supply non-redundancy and sticky throttle
  logic nonred;

  always_comb begin
    nonred = 1'b0;
    if (&present) begin
      nonred = util >= (breaker_low ? board_power_pkg::UTIL_DUAL_LOW
                                    : board_power_pkg::UTIL_DUAL_HIGH);
    end else if (|present) begin
      nonred = util >= (breaker_low ? board_power_pkg::UTIL_ONE_LOW
                                    : board_power_pkg::UTIL_ONE_HIGH);
    end
  end

  // throttle only lets go on reset, i.e. a power cycle of the board
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      nonredundant_o <= 1'b0;
      cpu_throttle_n_o <= 1'b1;
    end else begin
      nonredundant_o <= nonred;
      if (nonred && !line_high) begin
        cpu_throttle_n_o <= 1'b0;
      end
    end
  end

  // ==========================================================
  // failure capture and dirty lock
  logic [3:0] cpu_good_d_r;
  logic [7:0] fru_good_d_r;
  logic [3:0] cpu_fail_r;
  logic [7:0] fru_fail_r;
  logic dirty_r;
  logic [3:0] cpu_fall;
  logic [7:0] fru_fall;
  logic fail_evt;
  logic latch_d_r;
  logic latch_rise;
  logic s5_read;

  assign cpu_fall = cpu_good_d_r & ~cpu_good & cpu_reg_enable_o;
  assign fru_fall = fru_good_d_r & ~fru_good;
  assign fail_evt = |cpu_fall || |fru_fall;
  assign latch_rise = latch_s && !latch_d_r;
  assign s5_read = latch_rise && in_s5;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cpu_good_d_r <= '0;
      fru_good_d_r <= '0;
      latch_d_r <= 1'b0;
    end else begin
      cpu_good_d_r <= cpu_good;
      fru_good_d_r <= fru_good;
      latch_d_r <= latch_s;
    end
  end

  // a new failure in the clearing cycle wins and relocks the vector
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dirty_r <= 1'b0;
      cpu_fail_r <= '0;
      fru_fail_r <= '0;
    end else if (fail_evt && (!dirty_r || s5_read)) begin
      dirty_r <= 1'b1;
      cpu_fail_r <= cpu_fall;
      fru_fail_r <= fru_fall;
    end else if (s5_read) begin
      dirty_r <= 1'b0;
      cpu_fail_r <= '0;
      fru_fail_r <= '0;
    end
  end

  logic [26:0] live;
  logic [26:0] status_r;

  always_comb begin
    live = board_power_pkg::STAT_RESET;
    live[board_power_pkg::ST_CPU_FAIL +: 4] = cpu_fail_r | cpu_fall;
    live[board_power_pkg::ST_FRU_FAIL +: 8] = fru_fail_r | fru_fall;
    live[board_power_pkg::ST_NONRED] = nonredundant_o;
    live[board_power_pkg::ST_DIRTY] = dirty_r || fail_evt;
    live[board_power_pkg::ST_PRESENT +: 2] = present;
    live[board_power_pkg::ST_SUP_OK +: 2] = sup_ok;
    live[board_power_pkg::ST_SYS_GOOD] = system_good_out_o;
    live[board_power_pkg::ST_SLOT_GOOD +: 4] = slot_good_o;
    live[board_power_pkg::ST_THROTTLE] = !cpu_throttle_n_o;
    live[board_power_pkg::ST_BREAKER] = breaker_low;
    live[board_power_pkg::ST_LINE] = line_high;
    live[board_power_pkg::ST_SUPPLY_OK] = supply_ok_out_o;
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      status_r <= board_power_pkg::STAT_RESET;
    end else if (!dirty_r || s5_read) begin
      status_r <= live;
    end
  end

  // ==========================================================
  // snapshot queue: status changes wait here until read out; changes made while it is full collapse into one
  logic [26:0] pushed_r;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [26:0] fifo_out_data;
  logic push_valid;
  logic pop;

  assign push_valid = (status_r != pushed_r);

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pushed_r <= board_power_pkg::STAT_RESET;
    end else if (push_valid && fifo_in_ready) begin
      pushed_r <= status_r;
    end
  end

  status_fifo #(
    .WIDTH(board_power_pkg::STAT_W),
    .DEPTH(board_power_pkg::FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .in_valid_i(push_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i(status_r),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(pop),
    .out_data_o(fifo_out_data)
  );

  // ==========================================================
  // serial status shifter
  board_power_pkg::shift_state_e sh_state_r;
  logic [26:0] shift_r;
  logic [4:0] bit_cnt_r;
  logic sclk_d_r;
  logic sclk_fall;

  assign sclk_fall = !sclk_s && sclk_d_r;
  assign pop = latch_rise && fifo_out_valid;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sclk_d_r <= 1'b0;
    end else begin
      sclk_d_r <= sclk_s;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sh_state_r <= board_power_pkg::SH_IDLE;
      shift_r <= board_power_pkg::STAT_RESET;
      bit_cnt_r <= '0;
      shift_data_o <= 1'b0;
    end else if (latch_rise) begin
      sh_state_r <= board_power_pkg::SH_RUN;
      shift_r <= fifo_out_valid ? fifo_out_data : live;
      shift_data_o <= fifo_out_valid ? fifo_out_data[0] : live[0];
      bit_cnt_r <= '0;
    end else begin
      case (sh_state_r)
        board_power_pkg::SH_RUN: begin
          if (sclk_fall) begin
            if (bit_cnt_r == board_power_pkg::STAT_LAST) begin
              sh_state_r <= board_power_pkg::SH_DONE;
              shift_data_o <= 1'b0;
            end else begin
              shift_r <= {1'b0, shift_r[26:1]};
              shift_data_o <= shift_r[1];
              bit_cnt_r <= bit_cnt_r + 5'h01;
            end
          end
        end
        board_power_pkg::SH_DONE: begin
          sh_state_r <= board_power_pkg::SH_IDLE;
        end
        default: begin
          sh_state_r <= board_power_pkg::SH_IDLE;
        end
      endcase
    end
  end

endmodule // board_power_status_logic

// ==== verification/board_power_checker_props.sv ====
// port-level assertions for the board power status logic
`timescale 1ns/100ps
module board_power_checker (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic suspend_clock_i,
  // inputs watched
  input wire logic [1:0] supply_present_in_i,
  input wire logic [1:0] supply_ok_in_i,
  input wire logic rail_1v5_good_i,
  input wire logic [3:0] socket_occupied_n_i,
  input wire logic [7:0] fru_good_i,
  input wire logic [3:0] riser_present_i,
  input wire logic latch_strobe_i,
  input wire logic shift_clk_i,
  // outputs watched
  input wire logic supply_ok_out_o,
  input wire logic term_reg_enable_o,
  input wire logic [3:0] cpu_reg_enable_o,
  input wire logic global_reg_enable_o,
  input wire logic io_riser_enable_o,
  input wire logic clock_enable_n_o,
  input wire logic system_good_out_o,
  input wire logic cpu_throttle_n_o,
  input wire logic shift_data_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  // ==========
  // helpers: recent link edges, suspend edges counted while clocks run
  logic [3:0] ev_q;
  logic [12:0] su_n;
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ev_q <= 4'h0;
      su_n <= 13'h0;
    end else begin
      ev_q <= {ev_q[2:0], $fell(shift_clk_i) | $rose(latch_strobe_i)};
      if (clock_enable_n_o) begin
        su_n <= 13'h0;
      end else if ($rose(suspend_clock_i) && su_n != 13'h1FFF) begin
        su_n <= su_n + 13'h1;
      end
    end
  end
  // ==========
  // assertions; 3 cycles is the input sync plus output register
  a_supply_ok_both: assert property (
    $rose(supply_ok_out_o) |-> $past(&{supply_ok_in_i, supply_present_in_i}, 3))
    else $error("supply ok early");
  a_term_after_rail: assert property (
    term_reg_enable_o |-> $past(rail_1v5_good_i, 3)) else $error("term enable early");
  a_cpu_populated_only: assert property (
    (cpu_reg_enable_o & $past(socket_occupied_n_i, 3)) == 4'h0) else $error("empty socket on");
  a_global_order: assert property (
    global_reg_enable_o |-> io_riser_enable_o && $past(term_reg_enable_o)
      && $past(|cpu_reg_enable_o) && $past(|riser_present_i, 3)) else $error("riser early");
  a_clk_en_inverse: assert property (
    !clock_enable_n_o |-> $past(&fru_good_i, 3)) else $error("clocks early");
  // 48 to 53 ticks of 64 suspend edges allows for tick phase
  a_sys_good_wait: assert property (
    $rose(system_good_out_o) |-> su_n >= 13'hC00 && su_n <= 13'hD40) else $error("bad delay");
  a_data_on_edges: assert property (
    $changed(shift_data_o) |-> |ev_q) else $error("serial data moved alone");
  a_throttle_sticky: assert property (
    !cpu_throttle_n_o |=> !cpu_throttle_n_o) else $error("throttle released");
  c_sys_good: cover property ($rose(system_good_out_o));
  c_throttle: cover property ($fell(cpu_throttle_n_o));
  c_clk_on: cover property ($fell(clock_enable_n_o));
endmodule // board_power_checker

bind board_power_status_logic board_power_checker chk_i (.*);

// ==== verification/status_reader.sv ====
// management controller model that latches and shifts out the status vector
`timescale 1ns/100ps
module status_reader (
  // clock
  input wire logic ref_clk_i,
  // status link
  output logic latch_strobe_o,
  output logic shift_clk_o,
  input wire logic shift_data_i,
  // one finished read
  output logic [26:0] vec_o,
  output logic done_o
);
  initial begin
    {latch_strobe_o, shift_clk_o, done_o, vec_o} = '0;
  end
  // ==========
  // read at about 1 MHz; shift clock idles low between reads
  task automatic read_vec();
    latch_strobe_o <= 1'b1;
    repeat (8) @(posedge ref_clk_i);
    latch_strobe_o <= 1'b0;
    for (int i = 0; i < 27; i++) begin
      shift_clk_o <= 1'b1;
      vec_o[i] <= shift_data_i;
      repeat (10) @(posedge ref_clk_i);
      shift_clk_o <= 1'b0;
      repeat (10) @(posedge ref_clk_i);
    end
    done_o <= 1'b1;
    @(posedge ref_clk_i);
    done_o <= 1'b0;
  endtask
endmodule // status_reader

// ==== verification/test_board_power_status_logic.sv ====
// self-checking bench for the board power status logic
`timescale 1ns/100ps
module test_board_power_status_logic;
  // ==========
  // signals carry the design's port names
  logic ref_clk_i = 1'b0;
  logic suspend_clock_i = 1'b0;
  logic reset_n_i, power_request_i, rail_1v5_good_i, term_reg_good_i;
  logic breaker_setting_i, line_range_sense_i, s5_state_i, latch_strobe_i, shift_clk_i;
  logic [1:0] supply_present_in_i, supply_ok_in_i;
  logic [3:0] socket_occupied_n_i, cpu_reg_good_i, riser_present_i, cpu_reg_enable_o;
  logic [3:0] slot_3v3_good_i, slot_stby_good_i, slot_good_o, slot_iso_enable_o;
  logic [7:0] fru_good_i;
  logic [6:0] utilization_i;
  logic supply_ok_out_o, supply_on_n_o, term_reg_enable_o, global_reg_enable_o;
  logic io_riser_enable_o, clock_enable_n_o, system_good_out_o, nonredundant_o;
  logic cpu_throttle_n_o, shift_data_o, done;
  logic [26:0] vec;
  logic [53:0] e;
  logic [53:0] exp_q[$];
  logic [6:0] thr [4] = '{7'h25, 7'h2D, 7'h4A, 7'h5A};
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;

  board_power_status_logic dut (.*);
  status_reader bmc (.ref_clk_i, .latch_strobe_o(latch_strobe_i), .shift_clk_o(shift_clk_i),
    .shift_data_i(shift_data_o), .vec_o(vec), .done_o(done));

  always #25 ref_clk_i = ~ref_clk_i;
  // suspend clock far above 32 kHz so the 100 ms timers fit the run
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc % 3 == 2) begin
      suspend_clock_i <= ~suspend_clock_i;
    end
  end
  // ==========
  // tasks
  task automatic w(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  task automatic chk(input logic [26:0] got, input logic [26:0] want);
    cmp_count++;
    if (got !== want) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  // nine reads drain the snapshot fifo, the tenth is judged
  task automatic fl(input logic [26:0] m, input logic [26:0] v);
    repeat (9) begin
      exp_q.push_back(54'h0);
      bmc.read_vec();
    end
    exp_q.push_back({m, v});
    bmc.read_vec();
  endtask
  task automatic results();
    if (err_total == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ==========
  // read monitor; an empty mask only drains
  always @(posedge ref_clk_i) begin
    if (done) begin
      e = exp_q.pop_front();
      if (e[53:27] != 27'h0) begin
        chk(vec & e[53:27], e[26:0]);
      end
    end
  end
  // tests need about 56k cycles
  initial begin
    w(100000);
    err_total++;
    results();
  end
  // ==========
  // main sequence
  initial begin
    void'($urandom(32'hF9BD6BC4));
    {reset_n_i, power_request_i, rail_1v5_good_i, term_reg_good_i} <= '0;
    {breaker_setting_i, s5_state_i, supply_present_in_i, supply_ok_in_i, cpu_reg_good_i} <= '0;
    {fru_good_i, riser_present_i, slot_3v3_good_i, slot_stby_good_i, utilization_i} <= '0;
    socket_occupied_n_i <= 4'hF;
    line_range_sense_i <= 1'b1;
    w(8);
    reset_n_i <= 1'b1;
    power_request_i <= 1'b1;
    w(10);
    chk(27'(supply_on_n_o), 27'h1);
    breaker_setting_i <= 1'($urandom);
    utilization_i <= 7'($urandom % 37);
    {supply_present_in_i, supply_ok_in_i, rail_1v5_good_i, term_reg_good_i} <= 6'h3F;
    {fru_good_i, cpu_reg_good_i, riser_present_i, slot_3v3_good_i, slot_stby_good_i} <= 24'hFFF1FF;
    socket_occupied_n_i <= 4'hA;
    w(12000);
    chk(27'({system_good_out_o, slot_good_o, slot_iso_enable_o}), 27'h0);
    w(12000);
    chk(27'(cpu_reg_enable_o), 27'h5);
    chk(27'({global_reg_enable_o, io_riser_enable_o, term_reg_enable_o}), 27'h7);
    chk(27'({supply_ok_out_o, supply_on_n_o}), 27'h2);
    chk(27'({clock_enable_n_o, system_good_out_o}), 27'h1);
    chk(27'({slot_good_o, slot_iso_enable_o}), 27'hFF);
    fl(27'h7FFFFFF, {2'b11, breaker_setting_i, 24'h7FC000});
    for (int i = 0; i < 4; i++) begin
      supply_present_in_i <= (i < 2) ? 2'h3 : 2'h1;
      breaker_setting_i <= (i % 2 == 0);
      utilization_i <= thr[i] - 7'h1;
      w(3000);
      chk(27'(nonredundant_o), 27'h0);
      utilization_i <= thr[i];
      w(6);
      chk(27'(nonredundant_o), 27'h1);
    end
    line_range_sense_i <= 1'b0;
    w(6);
    utilization_i <= 7'h0;
    w(6);
    chk(27'({nonredundant_o, cpu_throttle_n_o}), 27'h0);
    supply_present_in_i <= 2'h3;
    line_range_sense_i <= 1'b1;
    // an empty socket's regulator dropping is not a failure
    cpu_reg_good_i <= 4'hD;
    w(3000);
    fru_good_i <= 8'hF7;
    w(10);
    fru_good_i <= 8'hD7;
    w(10);
    chk(27'(clock_enable_n_o), 27'h1);
    fl(27'h2282, 27'h2080);
    // controller has seen the locked failure and shuts the board down
    power_request_i <= 1'b0;
    w(6);
    chk(27'(supply_on_n_o), 27'h1);
    s5_state_i <= 1'b1;
    fl(27'h2000, 27'h0);
    w(4);
    results();
  end
endmodule // test_board_power_status_logic
